// *** verilog/mso_map.svh ***
/*
 Constants for the motion status output block: reset values of the
 status outputs and the bit positions of the general-purpose I/O
 vectors. Assumes it is included by its bare name.
*/
`ifndef MSO_MAP_SVH
`define MSO_MAP_SVH

// Reset values of the status outputs
`define MSO_READY_RST    1'b0
`define MSO_LIMIT_RST    1'b0
`define MSO_PAUSE_RST    1'b0
`define MSO_HOME_RST     1'b0
`define MSO_CURRENT_RST  1'b0
`define MSO_RELEASE_RST  1'b0
// Driver-ready qualify setting value that enables the extra check
`define MSO_DRIVER_READY_QUALIFY_ON    1'b1
// General output bit positions (general output n is bit n-1)
`define MSO_GOUT_CURRENT_OFF_OUT    0
`define MSO_GOUT_CON     1
`define MSO_GOUT_ACL     2
`define MSO_GOUT_CS      3
`define MSO_GOUT_FREE    4
`define MSO_GOUT_BRAKE   5
`define MSO_GOUT_TL      6
`define MSO_GOUT_GEN     7
// General input bit positions (general input n is bit n-1)
`define MSO_GIN_ALARM    0
`define MSO_GIN_END      1
`define MSO_GIN_SINGLE_ENDED_TIMING_IN     2
`define MSO_GIN_LIMIT    3
`define MSO_GIN_READY    4
`define MSO_GIN_DIFFERENTIAL_TIMING_IN     6

`endif

// *** verilog/mso_pkg.sv ***
/*
 Types for the motion status output block.
 Assumes nothing of its surroundings.
*/
package mso_pkg;
   // Width of the general I/O vectors
   typedef logic [7:0] mso_gio_t;
endpackage : mso_pkg

// *** verilog/mso_status.sv ***
/*
 Status output logic of a motion controller: ready, limiting condition,
 pause status, home position, brake release, and driver general I/O
 mapping. Assumes a single 100 MHz clock; command inputs are one-cycle
 pulses from logic on the same clock; driver connector inputs are
 asynchronous pins and are synchronised here.
*/
// Function
// - Ready only when idle, no sequence, no alarm
// - Qualify setting 1 also requires driver ready
// - Limit output follows driver limit input
// - Pause status while paused, command or input
// - Continue, clear, start-in-sequence, abort end pause
// - Home seek done: zero position, set home
// - After homing, stop at origin sets home
// - Current state 1 normally, 0 on cutoff/alarm
// - Release state 1 on any release source
// - Brake locked only when current and release 0
// - Both brake outputs always identical
// - Cancelled: driver outputs onto general outputs
// - Cancelled: driver inputs onto general inputs
// - Motion commands refused while motor moves
`include "mso_map.svh"
`timescale 1ns/10ps
`default_nettype none

module mso_status #(
   parameter int POS_W = 32
) (
   // Clock and reset
   input  wire logic               core_clk_in,
   input  wire logic               rst_in,
   // Internal motion state (same clock)
   input  wire logic               moving_in,
   input  wire logic               seq_running_in,
   input  wire logic               alarm_active_in,
   input  wire logic               current_cutoff_in,
   input  wire logic               at_origin_in,
   input  wire logic               home_seek_done_in,
   // Commands and pulses (same clock)
   input  wire logic               pause_cmd_in,
   input  wire logic               pause_sig_in,
   input  wire logic               continue_cmd_in,
   input  wire logic               pause_clear_cmd_in,
   input  wire logic               start_in,
   input  wire logic               abort_in,
   input  wire logic               motion_cmd_in,
   input  wire logic               sys_release_in,
   input  wire logic               remote_release_in,
   input  wire logic               release_cmd_in,
   // Configuration
   input  wire logic               driver_ready_qualify_in,
   input  wire logic               assign_cancel_in,
   input  wire mso_pkg::mso_gio_t  general_out_in,
   // Driver output sources (same clock)
   input  wire logic               current_off_src_in,
   input  wire logic               current_on_src_in,
   input  wire logic               alarm_deviation_clear_src_in,
   input  wire logic               resolution_sel_src_in,
   input  wire logic               release_src_in,
   input  wire logic               torque_limit_src_in,
   input  wire logic               gen_src_in,
   // Driver connector inputs (asynchronous pins)
   input  wire logic               drv_alarm_in,
   input  wire logic               drv_end_in,
   input  wire logic               single_ended_timing_in,
   input  wire logic               drv_limit_in,
   input  wire logic               drv_ready_in,
   input  wire logic               differential_timing_in,
   // Status outputs
   output var  logic               ready_out,
   output var  logic               limit_condition_status_out,
   output var  logic               pause_status_out,
   output var  logic               home_position_out,
   output var  logic               brake_release_out,
   output var  logic               sys_brake_release_out,
   output var  logic               motion_cmd_accept_out,
   output var  logic [POS_W-1:0]   position_command_value_out,
   // Driver connector outputs
   output var  logic               current_off_out,
   output var  logic               current_on_out,
   output var  logic               alarm_deviation_clear_out,
   output var  logic               resolution_sel_out,
   output var  logic               release_out,
   output var  logic               torque_limit_out,
   output var  logic               drv_gen_out,
   // General I/O when assignments are cancelled
   output var  mso_pkg::mso_gio_t  general_in_out,
   output var  mso_pkg::mso_gio_t  general_drv_out
);
   import mso_pkg::*;

   // -------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------
   // Six driver pins; first stage is read only by the second
   logic [5:0] pin_meta_q;
   logic [5:0] pin_sync_q;
   logic [5:0] pins;
   assign pins = {differential_timing_in, drv_ready_in, drv_limit_in,
                  single_ended_timing_in, drv_end_in, drv_alarm_in};

   // Two-flop synchroniser, no reset needed on data path
   always_ff @(posedge core_clk_in) begin
      pin_meta_q <= pins;
      pin_sync_q <= pin_meta_q;
   end

   logic s_alarm, s_end, s_single_ended_timing_in, s_limit, s_ready, s_differential_timing_in;
   assign s_alarm = pin_sync_q[0];
   assign s_end   = pin_sync_q[1];
   assign s_single_ended_timing_in  = pin_sync_q[2];
   assign s_limit = pin_sync_q[3];
   assign s_ready = pin_sync_q[4];
   assign s_differential_timing_in  = pin_sync_q[5];

   // -------------------------------------------------------------
   // Ready and motion command gate
   // -------------------------------------------------------------
   logic idle;
   assign idle = !moving_in && !seq_running_in && !alarm_active_in;

   // Ready registered; driver ready only counts when qualified
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         ready_out <= `MSO_READY_RST;
      end else begin
         ready_out <= idle && ((driver_ready_qualify_in != `MSO_DRIVER_READY_QUALIFY_ON)
                               || s_ready);
      end
   end

   // Accept pulse for a motion command only while not moving
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         motion_cmd_accept_out <= 1'b0;
      end else begin
         motion_cmd_accept_out <= motion_cmd_in && !moving_in;
      end
   end

   // -------------------------------------------------------------
   // Limiting condition
   // -------------------------------------------------------------
   // Follows the synchronised pin, three cycles from pin to output
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         limit_condition_status_out <= `MSO_LIMIT_RST;
      end else begin
         limit_condition_status_out <= s_limit;
      end
   end

   // -------------------------------------------------------------
   // Pause status
   // -------------------------------------------------------------
   logic pause_set, pause_clr;
   assign pause_set = pause_cmd_in || pause_sig_in;
   assign pause_clr = continue_cmd_in || pause_clear_cmd_in ||
                      (start_in && seq_running_in) || abort_in;

   // Set wins over clear so a new pause is never lost
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         pause_status_out <= `MSO_PAUSE_RST;
      end else if (pause_set) begin
         pause_status_out <= 1'b1;
      end else if (pause_clr) begin
         pause_status_out <= 1'b0;
      end
   end

   // -------------------------------------------------------------
   // Home position
   // -------------------------------------------------------------
   logic homed_q;

   // Homed flag remembers that a seek has succeeded once
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         homed_q <= 1'b0;
      end else if (home_seek_done_in) begin
         homed_q <= 1'b1;
      end
   end

   // Position command zeroed on successful seek
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         position_command_value_out <= '0;
      end else if (home_seek_done_in) begin
         position_command_value_out <= '0;
      end
   end

   // Home output on seek done, or stopped at origin once homed
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         home_position_out <= `MSO_HOME_RST;
      end else begin
         home_position_out <= home_seek_done_in ||
            (homed_q && at_origin_in && !moving_in);
      end
   end

   // -------------------------------------------------------------
   // Current, release and brake
   // -------------------------------------------------------------
   logic current_q, release_q;

   // Current holds 1 unless cut off or in alarm
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         current_q <= `MSO_CURRENT_RST;
      end else begin
         current_q <= !current_cutoff_in && !alarm_active_in;
      end
   end

   // Release state from any of the three sources
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         release_q <= `MSO_RELEASE_RST;
      end else begin
         release_q <= sys_release_in || remote_release_in ||
                      release_cmd_in;
      end
   end

   // Brake follows truth table even in reset: both states 0 = lock.
   // Two flops with the same input drive the connectors so they never differ.
   logic brake_d;
   assign brake_d = current_q || release_q;
   always_ff @(posedge core_clk_in) begin
      brake_release_out     <= rst_in ? 1'b0 : brake_d;
      sys_brake_release_out <= rst_in ? 1'b0 : brake_d;
   end

   // -------------------------------------------------------------
   // Driver outputs and general I/O mapping
   // -------------------------------------------------------------
   mso_gio_t drv_d;
   always_comb begin
      drv_d                   = '0;
      drv_d[`MSO_GOUT_CURRENT_OFF_OUT]   = current_off_src_in;
      drv_d[`MSO_GOUT_CON]    = current_on_src_in;
      drv_d[`MSO_GOUT_ACL]    = alarm_deviation_clear_src_in;
      drv_d[`MSO_GOUT_CS]     = resolution_sel_src_in;
      drv_d[`MSO_GOUT_FREE]   = release_src_in;
      drv_d[`MSO_GOUT_BRAKE]  = brake_d;
      drv_d[`MSO_GOUT_TL]     = torque_limit_src_in;
      drv_d[`MSO_GOUT_GEN]    = gen_src_in;
      if (assign_cancel_in) begin
         drv_d = general_out_in;
      end
   end

   // Register driver pins; pins carry general outputs when cancelled
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         general_drv_out           <= '0;
         current_off_out           <= 1'b0;
         current_on_out            <= 1'b0;
         alarm_deviation_clear_out <= 1'b0;
         resolution_sel_out        <= 1'b0;
         release_out               <= 1'b0;
         torque_limit_out          <= 1'b0;
         drv_gen_out               <= 1'b0;
      end else begin
         general_drv_out           <= drv_d;
         current_off_out           <= drv_d[`MSO_GOUT_CURRENT_OFF_OUT];
         current_on_out            <= drv_d[`MSO_GOUT_CON];
         alarm_deviation_clear_out <= drv_d[`MSO_GOUT_ACL];
         resolution_sel_out        <= drv_d[`MSO_GOUT_CS];
         release_out               <= drv_d[`MSO_GOUT_FREE];
         torque_limit_out          <= drv_d[`MSO_GOUT_TL];
         drv_gen_out               <= drv_d[`MSO_GOUT_GEN];
      end
   end

   // General inputs valid only while assignments are cancelled
   mso_gio_t gin_d;
   always_comb begin
      gin_d                  = '0;
      gin_d[`MSO_GIN_ALARM]  = s_alarm;
      gin_d[`MSO_GIN_END]    = s_end;
      gin_d[`MSO_GIN_SINGLE_ENDED_TIMING_IN]   = s_single_ended_timing_in;
      gin_d[`MSO_GIN_LIMIT]  = s_limit;
      gin_d[`MSO_GIN_READY]  = s_ready;
      gin_d[`MSO_GIN_DIFFERENTIAL_TIMING_IN]   = s_differential_timing_in;
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in || !assign_cancel_in) begin
         general_in_out <= '0;
      end else begin
         general_in_out <= gin_d;
      end
   end

endmodule : mso_status

`default_nettype wire

// *** testbench/mso_status_chk.sv ***
/* Port checker for mso_status.
   Assumes one clock and binding to every mso_status instance. */
`timescale 1ns/10ps
`default_nettype none
module mso_status_chk #(
   parameter int POS_W = 32
) (
   // Clock, reset and causes
   input wire logic core_clk_in, rst_in, moving_in, seq_running_in,
   input wire logic alarm_active_in, current_cutoff_in, at_origin_in,
   input wire logic home_seek_done_in, pause_cmd_in, pause_sig_in,
   input wire logic continue_cmd_in, pause_clear_cmd_in, abort_in,
   input wire logic motion_cmd_in, sys_release_in, remote_release_in,
   input wire logic release_cmd_in, driver_ready_qualify_in, drv_limit_in,
   // Status outputs
   input wire logic ready_out, limit_condition_status_out,
   input wire logic pause_status_out, home_position_out,
   input wire logic brake_release_out, sys_brake_release_out,
   input wire logic motion_cmd_accept_out,
   input wire logic [POS_W-1:0] position_command_value_out
);
   logic [2:0] rc_q;
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   // Cycles since reset; keeps $past away from reset-era values
   always_ff @(posedge core_clk_in) begin
      if (rst_in) rc_q <= 3'h0;
      else if (rc_q != 3'h7) rc_q <= rc_q + 3'h1;
   end
   ready_gate_a: assert property (rc_q != 3'h0 &&
      !$past(driver_ready_qualify_in) |-> ready_out ==
      $past(!moving_in && !seq_running_in && !alarm_active_in))
      else $error("ready wrong for motion state");
   limit_follow_a: assert property (rc_q > 3'h2 |->
      limit_condition_status_out == $past(drv_limit_in, 3))
      else $error("limit output not following pin");
   pause_set_a: assert property (pause_cmd_in || pause_sig_in
      |=> pause_status_out) else $error("pause not set");
   pause_clear_a: assert property (!pause_cmd_in && !pause_sig_in &&
      (continue_cmd_in || pause_clear_cmd_in || abort_in)
      |=> !pause_status_out) else $error("pause not cleared");
   brake_same_a: assert property (brake_release_out ==
      sys_brake_release_out) else $error("brake outputs differ");
   brake_table_a: assert property (rc_q > 3'h1 |->
      brake_release_out == $past((!current_cutoff_in && !alarm_active_in)
      || sys_release_in || remote_release_in || release_cmd_in, 2))
      else $error("brake output wrong");
   cmd_accept_a: assert property (rc_q != 3'h0 |->
      motion_cmd_accept_out == $past(motion_cmd_in && !moving_in))
      else $error("motion command accept wrong");
   home_done_a: assert property (home_seek_done_in && at_origin_in &&
      !moving_in |=> home_position_out && position_command_value_out == 0)
      else $error("home seek end not reported");
   // Main scenarios reached
   pause_cycle_c: cover property (pause_cmd_in ##1 continue_cmd_in);
   home_seek_c: cover property (home_seek_done_in);
   cmd_refused_c: cover property (motion_cmd_in && moving_in);
endmodule : mso_status_chk
bind mso_status mso_status_chk #(.POS_W(POS_W)) chk_u (.*);
`default_nettype wire

// *** testbench/mso_drv_model.sv ***
/* Motor driver model: shows requested status pin levels after a
   short or long answer time. Assumes the bench clock. */
`timescale 1ns/10ps
`default_nettype none
module mso_drv_model (
   input  wire logic       core_clk_in,
   input  wire logic       slow_in,  // Answer in 4 cycles, else 1
   input  wire logic [5:0] req_in,   // Wanted pin levels
   output var  logic [5:0] pins_out  // {differential_timing_in,ready,lim,single_ended_timing_in,end,alm}
);
   logic [3:0][5:0] dly_q = '0;
   // Pins move just after the edge, unrelated to the device's sampling
   always @(posedge core_clk_in) begin
      dly_q <= #1 {dly_q[2:0], req_in};
   end
   assign pins_out = slow_in ? dly_q[3] : dly_q[0];
endmodule : mso_drv_model
`default_nettype wire

// *** testbench/mso_status_tb.sv ***
/* Self-checking bench for mso_status.
   Assumes the driver model and the bound checker. */
`timescale 1ns/10ps
`default_nettype none
module mso_status_tb;
   import mso_pkg::*;
   logic core_clk_in = '0, rst_in = 1'h1, slow = '0;
   logic moving_in = '0, seq_running_in = '0, alarm_active_in = '0;
   logic current_cutoff_in = '0, at_origin_in = '0, start_in = '0;
   logic home_seek_done_in = '0, pause_cmd_in = '0, pause_sig_in = '0;
   logic continue_cmd_in = '0, pause_clear_cmd_in = '0, abort_in = '0;
   logic motion_cmd_in = '0, sys_release_in = '0, release_cmd_in = '0;
   logic remote_release_in = '0, driver_ready_qualify_in = '0;
   logic assign_cancel_in = '0, current_off_src_in = '0, gen_src_in = '0;
   logic current_on_src_in = '0, alarm_deviation_clear_src_in = '0;
   logic resolution_sel_src_in = '0, release_src_in = '0;
   logic torque_limit_src_in = '0;
   logic [5:0] req = '0;
   wire logic [5:0] pins;
   wire logic drv_alarm_in, drv_end_in, single_ended_timing_in;
   wire logic drv_limit_in, drv_ready_in, differential_timing_in;
   mso_gio_t general_out_in = '0, general_in_out, general_drv_out;
   logic ready_out, limit_condition_status_out, pause_status_out;
   logic home_position_out, brake_release_out, sys_brake_release_out;
   logic motion_cmd_accept_out, current_off_out, current_on_out;
   logic alarm_deviation_clear_out, resolution_sel_out, release_out;
   logic torque_limit_out, drv_gen_out;
   // Dedicated driver pins in source order, general output 8 first
   wire logic [6:0] drv_pins;
   logic [31:0] position_command_value_out;
   int n_mismatch = 0, comparisons = 0, cyc = 0;
   assign {differential_timing_in, drv_ready_in, drv_limit_in,
      single_ended_timing_in, drv_end_in, drv_alarm_in} = pins;
   assign drv_pins = {drv_gen_out, torque_limit_out, release_out,
      resolution_sel_out, alarm_deviation_clear_out, current_on_out,
      current_off_out};
   mso_status dut_u (.*);
   mso_drv_model drv_u (.core_clk_in(core_clk_in), .slow_in(slow),
      .req_in(req), .pins_out(pins));
   always #5 core_clk_in = ~core_clk_in;
   // Hang guard, far above the roughly 120 cycles the tests take
   always @(posedge core_clk_in) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         complete_run;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Inputs always move 1 ns after the edge
   task automatic step(input int n);
      repeat (n) @(posedge core_clk_in);
      #1;
   endtask : step
   task automatic t_ready;
      for (int i = 0; i < 8; i++) begin
         {moving_in, seq_running_in, alarm_active_in} = i[2:0];
         step(1);
         chk(ready_out, i == 0);
      end
      {moving_in, seq_running_in, alarm_active_in} = '0;
      driver_ready_qualify_in = 1'h1;
      step(6);
      chk(ready_out, 0);
      req[4] = 1'h1;
      step(6);
      chk(ready_out, 1);
      driver_ready_qualify_in = '0;
      $display("test ready done");
   endtask : t_ready
   task automatic t_limit;
      slow = 1'h1;
      req[3] = 1'h1;
      step(3);
      chk(limit_condition_status_out, 0);
      step(6);
      chk(limit_condition_status_out, 1);
      req[3] = '0;
      step(9);
      chk(limit_condition_status_out, 0);
      slow = '0;
      $display("test limit done");
   endtask : t_limit
   task automatic t_pause;
      seq_running_in = 1'h1;
      for (int i = 0; i < 4; i++) begin
         {pause_sig_in, pause_cmd_in} = i[0] ? 2'h2 : 2'h1;
         step(1);
         {pause_sig_in, pause_cmd_in} = '0;
         step(1);
         chk(pause_status_out, 1);
         {continue_cmd_in, pause_clear_cmd_in, start_in, abort_in} =
            4'h1 << i;
         step(1);
         {continue_cmd_in, pause_clear_cmd_in, start_in, abort_in} = '0;
         chk(pause_status_out, 0);
      end
      // Start outside a sequence must leave the pause in place
      pause_cmd_in = 1'h1;
      step(1);
      {pause_cmd_in, seq_running_in, start_in} = 3'h1;
      step(1);
      start_in = '0;
      abort_in = 1'h1;
      chk(pause_status_out, 1);
      step(1);
      abort_in = '0;
      $display("test pause done");
   endtask : t_pause
   task automatic t_home;
      at_origin_in = 1'h1;
      step(2);
      chk(home_position_out, 0);
      home_seek_done_in = 1'h1;
      step(1);
      home_seek_done_in = '0;
      chk(home_position_out, 1);
      chk(position_command_value_out, 0);
      {moving_in, at_origin_in} = 2'h2;
      step(2);
      chk(home_position_out, 0);
      {moving_in, at_origin_in} = 2'h1;
      step(1);
      chk(home_position_out, 1);
      at_origin_in = '0;
      $display("test home done");
   endtask : t_home
   task automatic t_brake;
      logic e;
      for (int i = 0; i < 16; i++) begin
         {release_cmd_in, remote_release_in, sys_release_in} =
            3'((4'h1 << i[3:2]) >> 1);
         {alarm_active_in, current_cutoff_in} = i[1:0];
         e = i[1:0] == 0 || i[3:2] != 0;
         step(2);
         chk(brake_release_out, e);
         chk(sys_brake_release_out, e);
      end
      {release_cmd_in, alarm_active_in, current_cutoff_in} = '0;
      step(2);
      $display("test brake done");
   endtask : t_brake
   task automatic t_accept;
      motion_cmd_in = 1'h1;
      step(1);
      chk(motion_cmd_accept_out, 1);
      moving_in = 1'h1;
      step(1);
      {motion_cmd_in, moving_in} = '0;
      chk(motion_cmd_accept_out, 0);
      $display("test accept done");
   endtask : t_accept
   task automatic t_map;
      {gen_src_in, torque_limit_src_in, release_src_in,
         resolution_sel_src_in, alarm_deviation_clear_src_in,
         current_on_src_in, current_off_src_in} = 7'h55;
      step(1);
      chk(general_drv_out, 8'hb5);
      chk(current_off_out, 1);
      chk(drv_pins, 7'h55);
      assign_cancel_in = 1'h1;
      general_out_in = 8'h4a;
      req = 6'h2b;
      step(6);
      chk(general_drv_out, 8'h4a);
      chk(current_off_out, 0);
      chk(drv_pins, 7'h2a);
      chk(general_in_out, 8'h4b);
      assign_cancel_in = '0;
      step(2);
      chk(general_in_out, 8'h00);
      req = '0;
      $display("test map done");
   endtask : t_map
   task automatic t_rst;
      rst_in = 1'h1;
      step(2);
      chk({ready_out, pause_status_out, brake_release_out}, 0);
      rst_in = '0;
      step(3);
      chk(brake_release_out, 1);
      $display("test reset done");
   endtask : t_rst
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : complete_run
   initial begin
      step(10);
      rst_in = '0;
      t_home;
      t_ready;
      t_limit;
      t_pause;
      t_brake;
      t_accept;
      t_map;
      t_rst;
      complete_run;
   end
endmodule : mso_status_tb
`default_nettype wire
